//--- logic/sdh_clock_reset_ctrl.sv
// apb register slice: clock divider, mode gating and soft reset
// for the sd host core
// assumes apb3 master on pclk; power_mode is synchronous to pclk
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - low phase code at bits 10-8, n+1 cycles
// - high phase code at bits 2-0, n+1 cycles
// - run mode passes clock only if bit0
// - sleep mode passes clock only if bit8
// - deep sleep always blocks; bit16 reads zero
// - soft reset bit holds core in reset
// - status bit1 shows clocks enabled and reset released
// - gating register clears to zero on reset
// - reset register clears to zero on reset
module sdh_clock_reset_ctrl
   import sdh_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [SDH_ADDR_W-1:0] paddr,
   input wire logic [SDH_DATA_W-1:0] pwdata,
   output logic [SDH_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pll_tick,
   input wire sdh_power_mode_t power_mode,
   output logic host_clk,
   output logic host_core_reset,
   output logic host_clocks_on
);

   ////////////////////////////////////////////////////////////////////////
   // declarations
   sdh_div_cfg_t div_cfg_reg;
   sdh_gates_t gates_reg;
   logic soft_reset_reg;
   logic flag_reg;
   logic host_clk_reg;
   logic [SDH_DATA_W-1:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic div_clk;
   logic gate_open;
   logic setup_ph;
   logic wr_done;
   logic [SDH_DATA_W-1:0] read_word;
   logic addr_hit;

   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic is_mapped(input logic [SDH_ADDR_W-1:0] a);
      is_mapped = (a == SDH_DIV_OFS) || (a == SDH_GATE_OFS) || (a == SDH_RST_OFS);
   endfunction

   function automatic logic wr_to(input logic [SDH_ADDR_W-1:0] a,
                                  input logic [SDH_ADDR_W-1:0] ofs);
      wr_to = (a == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // apb handshake: no wait states, answer decided in the setup cycle
   assign setup_ph = psel && !penable;
   assign wr_done = psel && penable && pready_reg && pwrite && !pslverr_reg;
   assign addr_hit = is_mapped(paddr);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= setup_ph;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_reg <= 1'b0;
      end else if (setup_ph) begin
         pslverr_reg <= !addr_hit;
      end else begin
         pslverr_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; only documented bits are ever nonzero
   always_comb begin
      read_word = SDH_ZERO_WORD;
      unique case (paddr)
         SDH_DIV_OFS: begin
            read_word[SDH_LOW_MSB:SDH_LOW_LSB] = div_cfg_reg.low_phase_count;
            read_word[SDH_HIGH_MSB:SDH_HIGH_LSB] = div_cfg_reg.high_phase_count;
         end
         SDH_GATE_OFS: begin
            read_word[SDH_RUN_BIT] = gates_reg.run_mode_gate;
            read_word[SDH_SLEEP_BIT] = gates_reg.sleep_mode_gate;
            read_word[SDH_DEEP_BIT] = 1'b0;
         end
         SDH_RST_OFS: begin
            read_word[SDH_SRST_BIT] = soft_reset_reg;
            read_word[SDH_FLAG_BIT] = flag_reg;
         end
         default: read_word = SDH_ZERO_WORD;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= SDH_ZERO_WORD;
      end else if (setup_ph && !pwrite) begin
         prdata_reg <= read_word;
      end else begin
         prdata_reg <= SDH_ZERO_WORD;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // writable fields; everything else is dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cfg_reg <= SDH_DIV_RST;
      end else if (wr_done && wr_to(paddr, SDH_DIV_OFS)) begin
         div_cfg_reg.low_phase_count <= pwdata[SDH_LOW_MSB:SDH_LOW_LSB];
         div_cfg_reg.high_phase_count <= pwdata[SDH_HIGH_MSB:SDH_HIGH_LSB];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gates_reg <= SDH_GATES_RST;
      end else if (wr_done && wr_to(paddr, SDH_GATE_OFS)) begin
         gates_reg.run_mode_gate <= pwdata[SDH_RUN_BIT];
         gates_reg.sleep_mode_gate <= pwdata[SDH_SLEEP_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_reset_reg <= 1'b0;
      end else if (wr_done && wr_to(paddr, SDH_RST_OFS)) begin
         soft_reset_reg <= pwdata[SDH_SRST_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // divider
   sdh_clk_div u_div (
      .pclk(pclk),
      .presetn(presetn),
      .pll_tick(pll_tick),
      .div_cfg(div_cfg_reg),
      .div_clk(div_clk)
   );

   ////////////////////////////////////////////////////////////////////////
   // mode gating; an unknown mode code is treated as deep sleep
   always_comb begin
      unique case (power_mode)
         SDH_MODE_RUN: gate_open = gates_reg.run_mode_gate;
         SDH_MODE_SLEEP: gate_open = gates_reg.sleep_mode_gate;
         SDH_MODE_DEEP: gate_open = 1'b0;
         default: gate_open = 1'b0;
      endcase
   end

   // gating is done on a register so the core never sees a glitch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_clk_reg <= 1'b0;
      end else begin
         host_clk_reg <= div_clk && gate_open;
      end
   end

   // clocks on and reset released; lags the gate by one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= gate_open && !soft_reset_reg;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign host_clk = host_clk_reg;
   assign host_core_reset = soft_reset_reg;
   assign host_clocks_on = flag_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_apb_write(logic [SDH_ADDR_W-1:0] ofs);
      psel && !penable && pwrite && paddr == ofs
      ##1 psel && penable && pwrite && pready_reg && paddr == ofs;
   endsequence

   sequence s_apb_read(logic [SDH_ADDR_W-1:0] ofs);
      psel && !penable && !pwrite && paddr == ofs
      ##1 psel && penable && pready_reg;
   endsequence

   a_low_code_load: assert property (@(posedge pclk) disable iff (!presetn)
      s_apb_write(SDH_DIV_OFS)
      |=> div_cfg_reg.low_phase_count == $past(pwdata[SDH_LOW_MSB:SDH_LOW_LSB]))
      else $error("low phase code not loaded");

   a_high_code_load: assert property (@(posedge pclk) disable iff (!presetn)
      s_apb_write(SDH_DIV_OFS)
      |=> div_cfg_reg.high_phase_count == $past(pwdata[SDH_HIGH_MSB:SDH_HIGH_LSB]))
      else $error("high phase code not loaded");

   a_run_gate_pass: assert property (@(posedge pclk) disable iff (!presetn)
      (power_mode == SDH_MODE_RUN)
      |=> host_clk_reg == ($past(div_clk) && $past(gates_reg.run_mode_gate)))
      else $error("run mode gating wrong");

   a_sleep_gate_pass: assert property (@(posedge pclk) disable iff (!presetn)
      (power_mode == SDH_MODE_SLEEP)
      |=> host_clk_reg == ($past(div_clk) && $past(gates_reg.sleep_mode_gate)))
      else $error("sleep mode gating wrong");

   a_deep_sleep_block: assert property (@(posedge pclk) disable iff (!presetn)
      (power_mode == SDH_MODE_DEEP)[*2] |-> !host_clk_reg)
      else $error("clock passed in deep sleep");

   a_deep_bit_zero: assert property (@(posedge pclk) disable iff (!presetn)
      s_apb_read(SDH_GATE_OFS) |-> !prdata_reg[SDH_DEEP_BIT])
      else $error("deep sleep bit read nonzero");

   a_soft_reset_set: assert property (@(posedge pclk) disable iff (!presetn)
      s_apb_write(SDH_RST_OFS)
      |=> host_core_reset == $past(pwdata[SDH_SRST_BIT]))
      else $error("soft reset not following write");

   a_soft_reset_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (host_core_reset && !wr_done) |=> host_core_reset)
      else $error("soft reset dropped without write");

   a_flag_reads: assert property (@(posedge pclk) disable iff (!presetn)
      s_apb_read(SDH_RST_OFS)
      |-> prdata_reg[SDH_FLAG_BIT] == $past(flag_reg)
          && prdata_reg[SDH_SRST_BIT] == $past(soft_reset_reg))
      else $error("status bits read wrong");

   a_flag_tracks: assert property (@(posedge pclk) disable iff (!presetn)
      soft_reset_reg |=> !host_clocks_on)
      else $error("status on while core held in reset");

   a_reset_clear: assert property (@(posedge pclk)
      !presetn |-> gates_reg == SDH_GATES_RST && !soft_reset_reg && !flag_reg)
      else $error("registers not cleared by reset");

   a_gate_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      s_apb_read(SDH_GATE_OFS)
      |-> (prdata_reg & ~((32'h1 << SDH_RUN_BIT) | (32'h1 << SDH_SLEEP_BIT))) == 32'h0)
      else $error("reserved gate bits nonzero");

   a_div_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      s_apb_read(SDH_DIV_OFS) |-> prdata_reg[31:11] == 21'h0 && prdata_reg[7:3] == 5'h0)
      else $error("reserved divider bits nonzero");

   a_rst_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      s_apb_read(SDH_RST_OFS) |-> prdata_reg[31:2] == 30'h0)
      else $error("reserved reset bits nonzero");

   a_bad_addr_err: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_ph && !addr_hit) |=> pready_reg && pslverr_reg)
      else $error("unmapped address not refused");

   a_status_follows: assert property (@(posedge pclk) disable iff (!presetn)
      (gate_open && !soft_reset_reg) |=> host_clocks_on)
      else $error("status off while clocks enabled");

   a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
      (pready_reg && psel && penable) |=> !pready_reg)
      else $error("ready stood longer than one cycle");

   // a refused write must not touch any writable field
   a_bad_write_drop: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_ph && pwrite && !addr_hit) ##1 (psel && penable && pready_reg)
      |=> $stable(gates_reg) && $stable(div_cfg_reg) && $stable(soft_reset_reg))
      else $error("write to unmapped address landed");

endmodule

//--- include/sdh_pkg.sv
// package for the sd host clock and reset control slice
// assumes one apb clock; pll cycles arrive as one-cycle enable pulses
package sdh_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register byte addresses
   localparam logic [7:0] SDH_DIV_OFS = 8'h20;
   localparam logic [7:0] SDH_GATE_OFS = 8'h24;
   localparam logic [7:0] SDH_RST_OFS = 8'h28;
   localparam int SDH_ADDR_W = 8;
   localparam int SDH_DATA_W = 32;

   ////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int SDH_LOW_LSB = 8;
   localparam int SDH_LOW_MSB = 10;
   localparam int SDH_HIGH_LSB = 0;
   localparam int SDH_HIGH_MSB = 2;
   localparam int SDH_CODE_W = 3;
   localparam int SDH_RUN_BIT = 0;
   localparam int SDH_SLEEP_BIT = 8;
   localparam int SDH_DEEP_BIT = 16;
   localparam int SDH_SRST_BIT = 0;
   localparam int SDH_FLAG_BIT = 1;

   ////////////////////////////////////////////////////////////////////////
   // reset values and timing
   localparam logic [2:0] SDH_CODE_RST = 3'h0;
   localparam logic [31:0] SDH_ZERO_WORD = 32'h0000_0000;
   localparam int SDH_PLL_MHZ = 240;
   localparam int SDH_PCLK_MHZ = 10;

   ////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      SDH_MODE_RUN,
      SDH_MODE_SLEEP,
      SDH_MODE_DEEP
   } sdh_power_mode_t;

   typedef struct packed {
      logic sleep_mode_gate;
      logic run_mode_gate;
   } sdh_gates_t;

   typedef struct packed {
      logic [SDH_CODE_W-1:0] low_phase_count;
      logic [SDH_CODE_W-1:0] high_phase_count;
   } sdh_div_cfg_t;

   localparam sdh_gates_t SDH_GATES_RST = '{sleep_mode_gate: 1'b0, run_mode_gate: 1'b0};
   localparam sdh_div_cfg_t SDH_DIV_RST = '{low_phase_count: SDH_CODE_RST,
                                           high_phase_count: SDH_CODE_RST};

endpackage

//--- logic/sdh_clk_div.sv
// high/low phase divider of the pll clock for the sd host core
// assumes pll_tick is one pclk-wide pulse per pll cycle
`timescale 1ns/10ps
module sdh_clk_div
   import sdh_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pll_tick,
   input wire sdh_div_cfg_t div_cfg,
   output logic div_clk
);

   logic [SDH_CODE_W-1:0] phase_cnt_reg;
   logic div_clk_reg;
   logic [SDH_CODE_W-1:0] limit;

   ////////////////////////////////////////////////////////////////////////
   // a code n stands for n+1 pll cycles, so the count ends at the code
   assign limit = div_clk_reg ? div_cfg.high_phase_count : div_cfg.low_phase_count;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_cnt_reg <= SDH_CODE_RST;
         div_clk_reg <= 1'b1;
      end else if (pll_tick) begin
         if (phase_cnt_reg >= limit) begin
            // >= so a shortened code mid-phase cannot strand the counter
            phase_cnt_reg <= SDH_CODE_RST;
            div_clk_reg <= ~div_clk_reg;
         end else begin
            phase_cnt_reg <= phase_cnt_reg + 3'h1;
         end
      end
   end

   assign div_clk = div_clk_reg;

   ////////////////////////////////////////////////////////////////////////
   // phase end checks
   a_high_phase_end: assert property (@(posedge pclk) disable iff (!presetn)
      (pll_tick && div_clk_reg && phase_cnt_reg == div_cfg.high_phase_count)
      |=> !div_clk_reg)
      else $error("high phase did not end at its count");

   a_low_phase_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (pll_tick && !div_clk_reg && phase_cnt_reg < div_cfg.low_phase_count)
      |=> !div_clk_reg && phase_cnt_reg == $past(phase_cnt_reg) + 3'h1)
      else $error("low phase ended early");

endmodule

//--- testbench/sdh_core_model.sv
// far-side model of the sd host core: measures the phases of its clock
// assumes host_clk is a level sampled on pclk, one pclk per pll tick
`timescale 1ns/10ps
module sdh_core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic host_clk,
   input wire logic host_core_reset,
   output int hi_len,
   output int lo_len,
   output int rises,
   output logic in_reset
);
   logic last;
   int cnt;
   ////////////////////////////////////////
   // phase length in pclk cycles; only complete phases are reported
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last <= 1'b0;
         cnt <= 0;
         hi_len <= 0;
         lo_len <= 0;
         rises <= 0;
      end else if (host_clk !== last) begin
         if (last) hi_len <= cnt;
         else lo_len <= cnt;
         if (host_clk) rises <= rises + 1;
         last <= host_clk;
         cnt <= 1;
      end else begin
         cnt <= cnt + 1;
      end
   end
   // core logic is held while the soft reset is high
   assign in_reset = host_core_reset;
endmodule

//--- testbench/tb.sv
// self-checking bench: apb master, random phase codes and mode gating
// assumes the far side of the host clock is sdh_core_model
`timescale 1ns/10ps
module tb;
   import sdh_pkg::*;
   logic pclk = 1'b0;
   // no initialiser: the first reset is an event, so the async reset branches run at time zero
   logic presetn;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pll_tick = 1'b1;
   sdh_power_mode_t power_mode = SDH_MODE_RUN;
   logic host_clk;
   logic host_core_reset;
   logic host_clocks_on;
   int hi_len;
   int lo_len;
   int rises;
   logic in_reset;
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic err;
   logic [2:0] h;
   logic [2:0] l;
   int r0;
   sdh_clock_reset_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pll_tick(pll_tick),
      .power_mode(power_mode), .host_clk(host_clk),
      .host_core_reset(host_core_reset), .host_clocks_on(host_clocks_on));
   sdh_core_model u_core (.pclk(pclk), .presetn(presetn), .host_clk(host_clk),
      .host_core_reset(host_core_reset), .hi_len(hi_len), .lo_len(lo_len),
      .rises(rises), .in_reset(in_reset));
   always #50 pclk = ~pclk;
   ////////////////////////////////////////
   task automatic tally_and_finish();
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // holds the request until pready is sampled high; bounded wait
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      if (n >= 50) errors++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic exp_open(input int m, input logic [1:0] g);
      return (m == 0) ? g[0] : (m == 1) ? g[1] : 1'b0;
   endfunction
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////
   initial begin
      presetn <= 1'b0;
      r0 = $urandom(32'hbabc);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, SDH_DIV_OFS, 32'h0);
      check("div reset", 32'h0, rd);
      apb(1'b0, SDH_GATE_OFS, 32'h0);
      check("gate reset", 32'h0, rd);
      apb(1'b0, SDH_RST_OFS, 32'h0);
      check("rst reset", 32'h0, rd);
      repeat (20) @(posedge pclk);
      check("clk gated after reset", 32'h0, {31'h0, host_clk});
      check("core reset idle", 32'h0, {31'h0, host_core_reset});
      apb(1'b1, SDH_GATE_OFS, 32'hffff_ffff);
      apb(1'b0, SDH_GATE_OFS, 32'h0);
      check("gate readback", 32'h0000_0101, rd);
      apb(1'b1, SDH_DIV_OFS, 32'hffff_ffff);
      apb(1'b0, SDH_DIV_OFS, 32'h0);
      check("div readback", 32'h0000_0707, rd);
      apb(1'b1, SDH_RST_OFS, 32'hffff_ffff);
      apb(1'b0, SDH_RST_OFS, 32'h0);
      check("rst held", 32'h0000_0001, rd);
      check("core in reset", 32'h1, {31'h0, in_reset});
      apb(1'b1, SDH_RST_OFS, 32'h0);
      apb(1'b0, SDH_RST_OFS, 32'h0);
      check("rst released", 32'h0000_0002, rd);
      check("core out of reset", 32'h0, {31'h0, in_reset});
      apb(1'b0, 8'h2c, 32'h0);
      check("unmapped read", 32'h0000_0001, {rd[30:0], err});
      apb(1'b1, 8'h2c, 32'hffff_ffff);
      check("unmapped write refused", 32'h0000_0001, {31'h0, err});
      // two code pair corners (0/7 and 7/0) plus random pairs, tick each cycle
      for (int i = 0; i < 10; i++) begin
         h = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'($urandom % 8);
         l = (i == 0) ? 3'h7 : (i == 1) ? 3'h0 : 3'($urandom % 8);
         apb(1'b1, SDH_DIV_OFS, {21'h0, l, 5'h1f, h});
         repeat (40) @(posedge pclk);
         check("high length", 32'(h) + 32'h1, hi_len);
         check("low length", 32'(l) + 32'h1, lo_len);
      end
      apb(1'b1, SDH_DIV_OFS, 32'h0);
      // every mode against every gate pair, ticks at random
      for (int m = 0; m < 4; m++) begin
         for (int g = 0; g < 4; g++) begin
            apb(1'b1, SDH_GATE_OFS, {23'h0, g[1], 7'h0, g[0]});
            power_mode <= sdh_power_mode_t'(m);
            repeat (4) @(posedge pclk);
            r0 = rises;
            repeat (30) begin
               @(posedge pclk);
               pll_tick <= 1'($urandom % 2);
            end
            check("clock passes", 32'(exp_open(m, g[1:0])), 32'(rises != r0));
            check("status flag", 32'(exp_open(m, g[1:0])), {31'h0, host_clocks_on});
         end
      end
      // soft reset held, then a reset in mid-run must clear both registers
      apb(1'b1, SDH_RST_OFS, 32'h0000_0001);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      check("core reset after mid reset", 32'h0, {31'h0, in_reset});
      apb(1'b0, SDH_GATE_OFS, 32'h0);
      check("gate after mid reset", 32'h0, rd);
      apb(1'b0, SDH_RST_OFS, 32'h0);
      check("rst after mid reset", 32'h0, rd);
      tally_and_finish();
   end
endmodule
